// ===== logic/bridge_fault_supervisor.sv
// fault filtering, flag latching and gate-state selection for an h-bridge driver
`timescale 1ns/1ps

module bridge_fault_supervisor #(
    parameter int FILTER_CYC = bridge_fault_pkg::FILTER_CYC,
    parameter int SHORT_FILTER_CYC = bridge_fault_pkg::SHORT_FILTER_CYC,
    parameter int RL_SINK_CYC = bridge_fault_pkg::RL_SINK_CYC,
    parameter int WDOG_TIMEOUT_CYC = bridge_fault_pkg::WDOG_TIMEOUT_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // device pins and analog comparators (asynchronous)
    input wire logic enable_pin,
    input wire logic dir_pin,
    input wire logic pwm_pin,
    input wire logic ext_sensor_off_pin,
    input wire logic supply_high_cmp_lo,
    input wire logic supply_high_cmp_hi,
    input wire logic supply_low_cmp,
    input wire logic pump_low_cmp,
    input wire logic heat_warn_cmp,
    input wire logic overheat_cmp,
    input wire logic stuck_reset_cmp,
    input wire logic [3:0] ds_over_cmp,
    // outputs: gate order high1, low1, high2, low2
    output logic [3:0] gate_source,
    output logic [3:0] gate_sink,
    output logic [3:0] gate_res_low,
    output logic pump_enable,
    output logic [1:0] ds_thresh_sel
);
    initial begin
        // short filter must outlast the four-cycle stale comparator after a gate turns on
        if (FILTER_CYC < 1 || FILTER_CYC > 4194303 || SHORT_FILTER_CYC < 5 || SHORT_FILTER_CYC > 4194303 ||
            RL_SINK_CYC < 1 || RL_SINK_CYC > 2047 || WDOG_TIMEOUT_CYC < 2 || WDOG_TIMEOUT_CYC > 8388607)
            $error("bridge_fault_supervisor: counts out of range");
    end

    localparam int NIN = 12;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [NIN-1:0] raw_in;
    logic [NIN-1:0] sync1;
    logic [NIN-1:0] sync2;
    logic [NIN-1:0] sync3;
    logic [NIN-1:0] pin;
    assign raw_in = {ds_over_cmp, stuck_reset_cmp, overheat_cmp, heat_warn_cmp, pump_low_cmp,
                     supply_low_cmp, supply_high_cmp_hi, supply_high_cmp_lo, ext_sensor_off_pin};
    logic [2:0] ctl_s1;
    logic [2:0] ctl_s2;
    logic [2:0] ctl_s3;
    logic [2:0] ctl;

    // three stages; a change counts once stages two and three agree
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1 <= 12'h001; // sensor pin idles high, no false trip after reset
            sync2 <= 12'h001;
            sync3 <= 12'h001;
            ctl_s1 <= '0;
            ctl_s2 <= '0;
            ctl_s3 <= '0;
        end else begin
            sync1 <= raw_in;
            sync2 <= sync1;
            sync3 <= sync2;
            ctl_s1 <= {pwm_pin, dir_pin, enable_pin};
            ctl_s2 <= ctl_s1;
            ctl_s3 <= ctl_s2;
        end
    end

    // settled levels: the sensor pin idles high, so it resets high
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin <= 12'h001;
            ctl <= 3'h0;
        end else begin
            for (int i = 0; i < NIN; i++) begin
                if (sync2[i] == sync3[i])
                    pin[i] <= sync3[i];
            end
            for (int j = 0; j < 3; j++) begin
                if (ctl_s2[j] == ctl_s3[j])
                    ctl[j] <= ctl_s3[j];
            end
        end
    end

    logic sensor_high, standby;
    assign sensor_high = pin[0];
    assign standby = ~ctl[0];

    // ****************************************************************
    // registers
    // ****************************************************************
    logic [5:0] ctrl;
    logic supply_fault_restart_sel;
    logic ov_thresh_sel;
    logic sensor_pin_mode_sel;
    logic wdog_en;
    assign supply_fault_restart_sel = ctrl[bridge_fault_pkg::CTRL_SUPPLY_FAULT_RESTART_SEL];
    assign ov_thresh_sel = ctrl[bridge_fault_pkg::CTRL_OV_THRESH_SEL];
    assign sensor_pin_mode_sel = ctrl[bridge_fault_pkg::CTRL_SENSOR_PIN_MODE_SEL];
    assign wdog_en = ctrl[bridge_fault_pkg::CTRL_WDOG_EN];

    logic wr, rd;
    assign pready = 1'b1;
    assign wr = psel & penable & pwrite;
    assign rd = psel & ~penable & ~pwrite;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == bridge_fault_pkg::OFF_CTRL) || (a == bridge_fault_pkg::OFF_STATUS) ||
                 (a == bridge_fault_pkg::OFF_CLEAR) || (a == bridge_fault_pkg::OFF_WDOG) ||
                 (a == bridge_fault_pkg::OFF_GATES);
    endfunction
    assign pslverr = psel & penable & ~mapped(paddr);

    // control register; threshold steps steer the external comparators
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            ctrl <= bridge_fault_pkg::CTRL_RESET;
        else if (wr && paddr == bridge_fault_pkg::OFF_CTRL)
            ctrl <= pwdata[5:0];
    end
    assign ds_thresh_sel = ctrl[bridge_fault_pkg::CTRL_DS_THRESH_LSB +: 2];

    // clear strobe: write ones to the clear register
    logic [11:0] clr;
    assign clr = (wr && paddr == bridge_fault_pkg::OFF_CLEAR) ? pwdata[11:0] : 12'h000;
    logic wdog_kick;
    assign wdog_kick = wr && paddr == bridge_fault_pkg::OFF_WDOG && pwdata[0];

    // ****************************************************************
    // filters
    // ****************************************************************
    // gate modes fed back so drain-source checks only see sourcing gates
    logic [3:0] gate_src_q;
    logic [10:0] cond;
    logic [10:0] filt;
    assign cond[0] = ov_thresh_sel ? pin[2] : pin[1];
    assign cond[1] = pin[3];
    assign cond[2] = pin[4];
    assign cond[3] = pin[5];
    assign cond[4] = pin[6];
    assign cond[5] = pin[7];
    assign cond[6] = sensor_pin_mode_sel & ~sensor_high;
    assign cond[10:7] = pin[11:8] & gate_src_q;

    genvar g;
    generate
        for (g = 0; g < 11; g++) begin : gen_filt
            localparam int LIM = (g >= 7) ? SHORT_FILTER_CYC : FILTER_CYC;
            logic [21:0] cnt;
            // counter restarts on any drop, so only continuous faults pass
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst)
                    cnt <= '0;
                else if (!cond[g])
                    cnt <= '0;
                else if (cnt < 22'(LIM))
                    cnt <= cnt + 22'h1;
            end
            assign filt[g] = (cnt >= 22'(LIM));
        end
    endgenerate

    // ****************************************************************
    // watchdog
    // ****************************************************************
    logic [22:0] wdog_cnt;
    logic wdog_expired;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            wdog_cnt <= '0;
        else if (!wdog_en || wdog_kick)
            wdog_cnt <= '0;
        else if (wdog_cnt < 23'(WDOG_TIMEOUT_CYC))
            wdog_cnt <= wdog_cnt + 23'h1;
    end
    assign wdog_expired = (wdog_cnt >= 23'(WDOG_TIMEOUT_CYC));

    // ****************************************************************
    // flags: set wins over clear
    // ****************************************************************
    logic supply_high_flag, supply_low_flag, watchdog_timeout_flag, heat_warning_flag;
    logic overheat_shutdown_flag, pump_low_flag, external_overheat_flag, stuck_reset_flag;
    logic [3:0] drain_source_fault_flag;
    logic global_error_flag;
    logic pump_held;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            supply_high_flag <= 1'b0;
            supply_low_flag <= 1'b0;
            watchdog_timeout_flag <= 1'b0;
            heat_warning_flag <= 1'b0;
            overheat_shutdown_flag <= 1'b0;
            pump_low_flag <= 1'b0;
            stuck_reset_flag <= 1'b0;
            drain_source_fault_flag <= 4'h0;
        end else begin
            supply_high_flag <= filt[0] | (supply_high_flag & ~clr[0]);
            supply_low_flag <= filt[1] | (supply_low_flag & ~clr[1]);
            watchdog_timeout_flag <= wdog_expired | (watchdog_timeout_flag & ~clr[2]);
            heat_warning_flag <= filt[3] | (heat_warning_flag & ~clr[3]);
            // still-hot die re-sets the flag, so cooling is needed first
            overheat_shutdown_flag <= filt[4] | (overheat_shutdown_flag & ~clr[4]);
            // pump low is meaningless while the pump is deliberately off
            pump_low_flag <= (filt[2] & pump_enable) | (pump_low_flag & ~clr[5]);
            stuck_reset_flag <= filt[5] | (stuck_reset_flag & ~clr[7]);
            drain_source_fault_flag <= filt[10:7] | (drain_source_fault_flag & ~clr[11:8]);
        end
    end

    // sensor mode: filtered and latched; active-off: live pin, no latch
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            external_overheat_flag <= 1'b0;
        else if (!sensor_pin_mode_sel)
            external_overheat_flag <= ~sensor_high;
        else
            external_overheat_flag <= filt[6] | (external_overheat_flag & ~clr[6]);
    end
    assign global_error_flag = supply_high_flag | supply_low_flag | watchdog_timeout_flag |
                               overheat_shutdown_flag | pump_low_flag | external_overheat_flag |
                               stuck_reset_flag | (|drain_source_fault_flag);

    // ****************************************************************
    // charge pump
    // ****************************************************************
    // with restart select 1 the pump waits for the supply flag clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            pump_held <= 1'b0;
        else if (filt[0] | filt[1])
            pump_held <= 1'b1;
        else if (!supply_fault_restart_sel)
            pump_held <= 1'b0;
        else if (!supply_high_flag && !supply_low_flag)
            pump_held <= 1'b0;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            pump_enable <= 1'b0;
        else
            pump_enable <= ~standby & ~pump_held & ~overheat_shutdown_flag & ~filt[4];
    end

    // ****************************************************************
    // gate state selection
    // ****************************************************************
    logic all_rl, all_sink;
    logic [3:0] want_src;
    logic [3:0] hb_sink;
    assign all_rl = standby | overheat_shutdown_flag | pump_low_flag | stuck_reset_flag;
    // live sensor pin in active-off mode acts at once, not only via the flag
    assign all_sink = supply_high_flag | supply_low_flag | watchdog_timeout_flag |
                      external_overheat_flag | (~sensor_pin_mode_sel & ~sensor_high);
    assign hb_sink = {{2{|drain_source_fault_flag[3:2]}}, {2{|drain_source_fault_flag[1:0]}}};
    // dir selects which diagonal is on, pwm low brakes on both low sides
    assign want_src = ctl[2] ? (ctl[1] ? 4'b1001 : 4'b0110) : 4'b1010;

    generate
        for (g = 0; g < 4; g++) begin : gen_gate
            bridge_fault_pkg::gate_mode_t mode;
            bridge_fault_pkg::gate_mode_t next_mode;
            logic [10:0] rl_cnt;
            // heat warning deliberately absent from this decision
            always_comb begin
                if (all_rl)
                    next_mode = bridge_fault_pkg::GATE_RES_LOW;
                else if (all_sink || hb_sink[g] || !want_src[g])
                    next_mode = bridge_fault_pkg::GATE_SINK;
                else
                    next_mode = bridge_fault_pkg::GATE_DRIVE;
            end
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst)
                    mode <= bridge_fault_pkg::GATE_RES_LOW;
                else
                    mode <= next_mode;
            end
            // sink phase on every entry to resistive-low for fast turn-off
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst)
                    rl_cnt <= 11'(RL_SINK_CYC);
                else if (next_mode != bridge_fault_pkg::GATE_RES_LOW)
                    rl_cnt <= '0;
                else if (rl_cnt < 11'(RL_SINK_CYC))
                    rl_cnt <= rl_cnt + 11'h1;
            end
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    gate_source[g] <= 1'b0;
                    gate_sink[g] <= 1'b0;
                    gate_res_low[g] <= 1'b1;
                end else begin
                    gate_source[g] <= (next_mode == bridge_fault_pkg::GATE_DRIVE);
                    gate_sink[g] <= (next_mode == bridge_fault_pkg::GATE_SINK) ||
                                    (next_mode == bridge_fault_pkg::GATE_RES_LOW &&
                                     rl_cnt < 11'(RL_SINK_CYC));
                    gate_res_low[g] <= (next_mode == bridge_fault_pkg::GATE_RES_LOW) &&
                                       (rl_cnt >= 11'(RL_SINK_CYC));
                end
            end
            assign gate_src_q[g] = (mode == bridge_fault_pkg::GATE_DRIVE);
        end
    endgenerate

    // ****************************************************************
    // read data
    // ****************************************************************
    logic [bridge_fault_pkg::ST_WIDTH-1:0] status;
    assign status = {global_error_flag, drain_source_fault_flag, stuck_reset_flag,
                     external_overheat_flag, pump_low_flag, overheat_shutdown_flag,
                     heat_warning_flag, watchdog_timeout_flag, supply_low_flag, supply_high_flag};

    // read data captured in the setup cycle, valid in the access cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            prdata <= 32'h0000_0000;
        else if (rd) begin
            case (paddr)
                bridge_fault_pkg::OFF_CTRL: prdata <= {26'h0, ctrl};
                bridge_fault_pkg::OFF_STATUS: prdata <= {19'h0, status};
                bridge_fault_pkg::OFF_GATES: prdata <= {19'h0, pump_enable, gate_res_low, gate_sink, gate_source};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// ===== include/bridge_fault_pkg.sv
// constants, register map and gate-state codes for the bridge fault supervisor
package bridge_fault_pkg;
    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_HZ = 20000000;
    localparam int FILTER_US = 64;
    localparam int SHORT_FILTER_US = 6;
    localparam int RL_SINK_MIN_US = 32;
    localparam int RL_SINK_MAX_US = 64;
    // least times use the clock truncated to whole MHz
    localparam int FILTER_CYC = (FILTER_US * (CLK_HZ / 1000000));
    localparam int SHORT_FILTER_CYC = (SHORT_FILTER_US * (CLK_HZ / 1000000));
    // sink phase chosen at the short end of the window, clock truncated to whole MHz
    localparam int RL_SINK_CYC = (RL_SINK_MIN_US * (CLK_HZ / 1000000));
    localparam int WDOG_TIMEOUT_CYC = 2000000;

    // ****************************************************************
    // register map (byte offsets)
    // ****************************************************************
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_CLEAR = 8'h08;
    localparam logic [7:0] OFF_WDOG = 8'h0c;
    localparam logic [7:0] OFF_GATES = 8'h10;

    // control fields
    localparam int CTRL_SUPPLY_FAULT_RESTART_SEL = 0;
    localparam int CTRL_OV_THRESH_SEL = 1;
    localparam int CTRL_SENSOR_PIN_MODE_SEL = 2;
    localparam int CTRL_DS_THRESH_LSB = 3;
    localparam int CTRL_WDOG_EN = 5;
    localparam logic [5:0] CTRL_RESET = 6'h00;

    // status fields
    localparam int ST_SUPPLY_HIGH = 0;
    localparam int ST_SUPPLY_LOW = 1;
    localparam int ST_WDOG = 2;
    localparam int ST_HEAT_WARN = 3;
    localparam int ST_OVERHEAT = 4;
    localparam int ST_PUMP_LOW = 5;
    localparam int ST_EXT_HEAT = 6;
    localparam int ST_STUCK_RESET = 7;
    localparam int ST_DS_LSB = 8;
    localparam int ST_GLOBAL = 12;
    localparam int ST_WIDTH = 13;

    // ****************************************************************
    // gate output states
    // ****************************************************************
    typedef enum logic [2:0] {
        GATE_DRIVE = 3'b001,
        GATE_SINK = 3'b010,
        GATE_RES_LOW = 3'b100
    } gate_mode_t;
endpackage

// ===== testbench/bridge_model.sv
// behavioural model of the external mosfet bridge drain-source comparators
`timescale 1ns/1ps
module bridge_model (
    // gate state from the supervisor
    input wire logic [3:0] gate_source,
    // transistors the bench has shorted
    input wire logic [3:0] short_mask,
    // comparator outputs back to the supervisor
    output logic [3:0] ds_over_cmp
);
    // an off transistor carries the full supply, so its comparator always reads over
    assign ds_over_cmp = ~gate_source | short_mask;
endmodule

// ===== testbench/bridge_fault_assertions.sv
// concurrent checks on the bridge fault supervisor ports
`timescale 1ns/1ps
module bridge_fault_assertions #(
    parameter int RL_SINK_CYC = 6
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pslverr,
    // pins
    input wire logic enable_pin,
    input wire logic ext_sensor_off_pin,
    input wire logic supply_low_cmp,
    input wire logic [3:0] ds_over_cmp,
    // outputs
    input wire logic [3:0] gate_source,
    input wire logic [3:0] gate_sink,
    input wire logic [3:0] gate_res_low,
    input wire logic pump_enable,
    input wire logic [1:0] ds_thresh_sel
);
    logic sensor_mode;
    logic [7:0] low_cnt;
    wire [3:0] overlap = (gate_source & gate_sink) | (gate_source & gate_res_low) | (gate_sink & gate_res_low);
    // sensor mode mirrored from control writes, the register itself is not visible here
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) sensor_mode <= 1'b0;
        else if (psel && penable && pwrite && paddr == 8'h00) sensor_mode <= pwdata[2];
    end
    // saturating run length of the undervoltage comparator
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) low_cnt <= 8'h00;
        else if (!supply_low_cmp) low_cnt <= 8'h00;
        else if (low_cnt != 8'hff) low_cnt <= low_cnt + 8'h01;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence ctrl_wr_s; psel && penable && pwrite && paddr == 8'h00; endsequence
    sequence short_s; gate_source[0] && ds_over_cmp[0]; endsequence
    sequence half_sink_s; gate_sink[1:0] == 2'b11; endsequence
    gate_onehot_a: assert property (((gate_source | gate_sink | gate_res_low) == 4'hf) && overlap == 4'h0)
        else $error("gate state not one-hot");
    unmapped_err_a: assert property (psel && penable |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10}))
        else $error("slave error does not match address map");
    ds_thresh_a: assert property (ctrl_wr_s |=> ds_thresh_sel == $past(pwdata[4:3]))
        else $error("threshold step not taken from control write");
    rl_sink_a: assert property ($rose(gate_res_low[0]) && $past(gate_sink[0]) |-> $past(gate_sink[0], RL_SINK_CYC))
        else $error("sink phase before resistive low too short");
    standby_pump_a: assert property (!enable_pin [*6] |-> !pump_enable)
        else $error("pump on in standby");
    active_off_a: assert property ((!sensor_mode && !ext_sensor_off_pin) [*6] |-> gate_source == 4'h0)
        else $error("sensor pin trip left a gate sourcing");
    supply_low_a: assert property (low_cnt >= 8'd20 |-> !pump_enable && gate_source == 4'h0)
        else $error("undervoltage did not stop pump and gates");
    ds_short_a: assert property (short_s [*8] |-> ##[0:5] half_sink_s)
        else $error("short did not sink its half bridge");
endmodule

// ===== testbench/tb_top.sv
// self-checking bench for the bridge fault supervisor
`timescale 1ns/1ps
module tb_top;
    logic clk, nrst, psel, penable, pwrite, pready, pslverr, pump_enable;
    logic enable_pin, dir_pin, pwm_pin, ext_sensor_off_pin, sup_hi_lo, sup_hi_hi;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rnd;
    logic [4:0] fault_v;
    logic [3:0] short_mask, ds_over_cmp, gate_source, gate_sink, gate_res_low;
    logic [1:0] ds_thresh_sel;
    logic [64:0] exp_q[$];
    logic [4:0] tv[6];
    logic [11:0] ts[6];
    logic [12:0] tg[6], tm[6];
    int bad_count = 0;
    int tests_run = 0;
    int cycles = 0;
    // short counts keep each fault scenario to a few dozen cycles
    bridge_fault_supervisor #(.FILTER_CYC(8), .SHORT_FILTER_CYC(6), .RL_SINK_CYC(6), .WDOG_TIMEOUT_CYC(50)) dut_u (
        .clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .enable_pin, .dir_pin, .pwm_pin, .ext_sensor_off_pin,
        .supply_high_cmp_lo(sup_hi_lo), .supply_high_cmp_hi(sup_hi_hi), .supply_low_cmp(fault_v[4]),
        .pump_low_cmp(fault_v[3]), .heat_warn_cmp(fault_v[2]), .overheat_cmp(fault_v[1]),
        .stuck_reset_cmp(fault_v[0]), .ds_over_cmp, .gate_source, .gate_sink, .gate_res_low,
        .pump_enable, .ds_thresh_sel);
    bridge_model br_u (.gate_source, .short_mask, .ds_over_cmp);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ****************************************************************
    // apb master, waits, verdict
    // ****************************************************************
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
        exp_q.push_back({!(a inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10}), m, d});
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (!pready) @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // compare each completed transfer with the oldest note; a write only checks the error flag
    always @(posedge clk) begin
        if (psel && penable && pready) begin
            tests_run++;
            if (exp_q.size() == 0 || (prdata & exp_q[0][63:32]) !== (exp_q[0][31:0] & exp_q[0][63:32])
                || pslverr !== exp_q[0][64]) begin
                bad_count++;
                $display("CHECK FAILED %0t addr %h read %h", $time, paddr, prdata);
            end
            if (exp_q.size() > 0) void'(exp_q.pop_front());
        end
    end
    // hang guard, far above the roughly 1150 cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            bad_count++;
            print_verdict();
        end
    end
    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        {psel, penable, pwrite, paddr, pwdata, enable_pin, sup_hi_lo, sup_hi_hi, fault_v, short_mask} = '0;
        {dir_pin, pwm_pin, ext_sensor_off_pin} = 3'b111;
        nrst = 1'b0;
        tv = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h12};
        ts = '{12'h002, 12'h020, 12'h008, 12'h010, 12'h080, 12'h012};
        tg = '{13'h10f0, 13'h0f00, 13'h1069, 13'h0f00, 13'h0f00, 13'h0f00};
        tm = '{13'h1fff, 13'h0fff, 13'h1fff, 13'h1fff, 13'h0fff, 13'h1fff};
        void'($urandom(32'hbde17482));
        wt(12);
        nrst <= 1'b1;
        xfer(0, 8'h00, 32'h0, 32'h3f);
        xfer(0, 8'h10, 32'h0f00, 32'h1fff);
        xfer(1, 8'h14, $urandom, 32'h0);
        xfer(0, 8'h14, 32'h0, 32'hffffffff);
        enable_pin <= 1'b1;
        wt(10);
        xfer(0, 8'h10, 32'h1069, 32'h1fff);
        for (int k = 0; k < 4; k++) begin
            xfer(1, 8'h00, k << 3, 32'h0);
            xfer(0, 8'h00, k << 3, 32'h3f);
        end
        // glitch first, then a held fault, released before the clear
        for (int i = 0; i < 6; i++) begin
            fault_v <= tv[i];
            wt(6);
            fault_v <= 5'h00;
            wt(10);
            xfer(0, 8'h04, 32'h0, 32'hfff);
            fault_v <= tv[i];
            wt(30);
            fault_v <= 5'h00;
            wt(30);
            xfer(0, 8'h04, ts[i], 32'hfff);
            xfer(0, 8'h10, tg[i], tm[i]);
            rnd = $urandom;
            xfer(1, 8'h08, {rnd[31:12], 12'hfff}, 32'h0);
            wt(5);
            xfer(0, 8'h10, 32'h1069, 32'h1fff);
        end
        // overvoltage on the high threshold with restart selection 1
        xfer(1, 8'h00, 32'h3, 32'h0);
        sup_hi_lo <= 1'b1;
        wt(30);
        xfer(0, 8'h04, 32'h0, 32'h3);
        sup_hi_hi <= 1'b1;
        wt(30);
        {sup_hi_lo, sup_hi_hi} <= 2'b00;
        fault_v <= 5'h08;
        wt(30);
        xfer(0, 8'h10, 32'h00f0, 32'h1fff);
        xfer(1, 8'h08, 32'h1, 32'h0);
        wt(30);
        xfer(0, 8'h04, 32'h20, 32'h23);
        fault_v <= 5'h00;
        // let the comparator drain out of the filter, or the set beats the clear
        wt(10);
        xfer(1, 8'h08, 32'h20, 32'h0);
        wt(5);
        xfer(0, 8'h10, 32'h1069, 32'h1fff);
        // short on high side one; the other half bridge keeps driving
        xfer(1, 8'h00, $urandom & 32'h18, 32'h0);
        short_mask <= 4'h1;
        wt(30);
        short_mask <= 4'h0;
        wt(20);
        xfer(0, 8'h04, 32'h100, 32'hf00);
        xfer(0, 8'h10, 32'h078, 32'hfff);
        xfer(1, 8'h08, 32'h100, 32'h0);
        wt(5);
        xfer(0, 8'h10, 32'h1069, 32'h1fff);
        // active-off pin follows the level, no clear needed
        ext_sensor_off_pin <= 1'b0;
        wt(8);
        xfer(0, 8'h10, 32'h0f0, 32'hfff);
        xfer(0, 8'h04, 32'h40, 32'h40);
        ext_sensor_off_pin <= 1'b1;
        wt(8);
        xfer(0, 8'h10, 32'h1069, 32'h1fff);
        xfer(0, 8'h04, 32'h0, 32'h40);
        // watchdog served in time, then starved
        xfer(1, 8'h00, 32'h20, 32'h0);
        for (int k = 0; k < 3; k++) begin
            wt(30);
            xfer(1, 8'h0c, 32'h1, 32'h0);
        end
        xfer(0, 8'h04, 32'h0, 32'h4);
        wt(90);
        xfer(0, 8'h04, 32'h4, 32'h4);
        xfer(0, 8'h10, 32'h0f0, 32'hfff);
        xfer(1, 8'h00, 32'h0, 32'h0);
        xfer(1, 8'h08, 32'h4, 32'h0);
        wt(5);
        xfer(0, 8'h10, 32'h1069, 32'h1fff);
        // reverse diagonal, then brake on both low sides
        {dir_pin, pwm_pin} <= 2'b01;
        wt(10);
        xfer(0, 8'h10, 32'h1096, 32'h1fff);
        pwm_pin <= 1'b0;
        wt(10);
        xfer(0, 8'h10, 32'h105a, 32'h1fff);
        {dir_pin, pwm_pin} <= 2'b11;
        enable_pin <= 1'b0;
        wt(20);
        xfer(0, 8'h10, 32'h0f00, 32'h1fff);
        print_verdict();
    end
endmodule
bind bridge_fault_supervisor bridge_fault_assertions #(.RL_SINK_CYC(RL_SINK_CYC)) chk_u (
    .clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr, .enable_pin, .ext_sensor_off_pin,
    .supply_low_cmp, .ds_over_cmp, .gate_source, .gate_sink, .gate_res_low, .pump_enable, .ds_thresh_sel);
